// File: design/dpk_pkg.sv
/*
  Shared constants, field layouts, timing figures and types for the decoder
  provisioning and key generation block.
  Assumes a 100 MHz core clock; all cycle counts are derived from that rate.
*/
package dpk_pkg;
  localparam int CLK_MHZ = 100;
  localparam int CYC_PER_US = CLK_MHZ;
  localparam int CYC_PER_MS = CLK_MHZ * 1000;
  localparam int TIMER_W = 32;

  localparam int PROG_ENTRY_SETUP_MIN_MS = 1;
  localparam int PROG_ENTRY_SETUP_MAX_MS = 64;
  localparam int PROG_ENTRY_HOLD_MIN_MS = 8;
  localparam int PROG_ENTRY_HOLD_MAX_MS = 128;
  localparam int PROG_PHASE_MAX_MS = 320;
  localparam int PROG_ACK_MAX_MS = 80;
  localparam int PROG_ACK_PULSE_US = 20;
  localparam int LEARN_STATUS_MS = 4000;
  localparam int LEARN_BLINK_MS = 250;

  localparam logic [TIMER_W-1:0] SETUP_MIN_CYC = TIMER_W'(PROG_ENTRY_SETUP_MIN_MS * CYC_PER_MS);
  localparam logic [TIMER_W-1:0] SETUP_MAX_CYC = TIMER_W'(PROG_ENTRY_SETUP_MAX_MS * CYC_PER_MS);
  localparam logic [TIMER_W-1:0] HOLD_MIN_CYC = TIMER_W'(PROG_ENTRY_HOLD_MIN_MS * CYC_PER_MS);
  localparam logic [TIMER_W-1:0] HOLD_MAX_CYC = TIMER_W'(PROG_ENTRY_HOLD_MAX_MS * CYC_PER_MS);
  localparam logic [TIMER_W-1:0] PHASE_MAX_CYC = TIMER_W'(PROG_PHASE_MAX_MS * CYC_PER_MS);
  localparam logic [TIMER_W-1:0] ACK_PULSE_CYC = TIMER_W'(PROG_ACK_PULSE_US * CYC_PER_US);
  localparam logic [TIMER_W-1:0] STATUS_CYC = TIMER_W'(LEARN_STATUS_MS * CYC_PER_MS);
  localparam logic [TIMER_W-1:0] BLINK_CYC = TIMER_W'(LEARN_BLINK_MS * CYC_PER_MS);

  localparam int MSG_BITS = 80;
  localparam int MSG_BYTES = 10;
  localparam int BYTE_W = 8;
  localparam int CODE_BITS = 64;
  localparam int HALF_W = 32;
  localparam int CNT_W = 7;
  localparam int CFG_BYTE_IDX = 8;

  localparam int CFG_KEY_ALGO_BIT = 0;
  localparam int CFG_UNUSED_ALGO_BIT = 1;
  localparam int CFG_SEED_LEARN_BIT = 2;
  localparam int CFG_SLEEP_BIT = 3;
  localparam logic [BYTE_W-1:0] CFG_RESET = 8'h00;

  localparam int SER24_W = 24;
  localparam int SER28_W = 28;
  localparam int SER_HI_W = 16;
  localparam logic [7:0] SEED_PFX24_UP = 8'h65;
  localparam logic [7:0] SEED_PFX24_LO = 8'h2B;
  localparam logic [3:0] SEED_PFX28_UP = 4'h6;
  localparam logic [3:0] SEED_PFX28_LO = 4'h2;
  localparam logic [3:0] FUNC_ZERO = 4'h0;
  localparam logic [HALF_W-1:0] SEED_TOP_MASK = 32'h0FFF_FFFF;

  localparam int SLOTS = 4;
  localparam int SLOT_W = 2;

  typedef enum logic [1:0] {TX_LEN_56, TX_LEN_66, TX_LEN_67} dpk_txlen_t;
  typedef enum logic [1:0] {SEED_32, SEED_48, SEED_64} dpk_seedkind_t;
  typedef enum {ST_WAIT_LOW, ST_HOLD, ST_PROG, ST_CHECK, ST_ACK, ST_ERASE, ST_RUN} dpk_state_t;
  typedef enum {KG_IDLE, KG_UP, KG_LO} dpk_kg_state_t;
endpackage

// File: design/dpk_link_if.sv
/*
  Carrier between the programming link logic and the core logic.
  Assumes the link side writes both signals on the link clock only.
*/
`timescale 1ns/1ns
interface dpk_link_if;
  logic [dpk_pkg::CNT_W-1:0] cnt_gray;
  logic [dpk_pkg::MSG_BITS-1:0] word;

  modport link (output cnt_gray, output word);
  modport core (input cnt_gray, input word);
endinterface

// File: design/dpk_prog_link.sv
/*
  Programming link receiver: shifts the data line on every rising edge of
  the programming clock and publishes a gray-coded edge count.
  Assumes the programming clock toggles at least three times while reset
  is held, and once more after release before the entry rise: the
  link-side reset needs two edges to clear, and otherwise swallows the
  first data edge.
*/
`timescale 1ns/1ns
module dpk_prog_link (
  // Link clock and data
  input wire logic i_link_clk,
  input wire logic i_link_data,
  // Core reset, resynchronised here
  input wire logic i_sys_rst,
  // Towards the core
  dpk_link_if.link lnk
);
  import dpk_pkg::*;

  logic rst_meta;
  logic rst_sync;
  logic [CNT_W-1:0] bin_cnt;
  logic [CNT_W-1:0] next_bin_cnt;
  logic [MSG_BITS-1:0] shreg;

  assign next_bin_cnt = bin_cnt + 1'b1;
  assign lnk.word = shreg;

  always_ff @(posedge i_link_clk) begin
    rst_meta <= i_sys_rst;
    rst_sync <= rst_meta;
  end

  // Only one bit of the count changes per edge, so the core can sample it safely
  always_ff @(posedge i_link_clk) begin
    if (rst_sync) begin
      bin_cnt <= '0;
      lnk.cnt_gray <= '0;
    end else begin
      bin_cnt <= next_bin_cnt;
      lnk.cnt_gray <= next_bin_cnt ^ (next_bin_cnt >> 1);
    end
  end

  // First bit in ends at bit 0 after eighty edges
  always_ff @(posedge i_link_clk) begin
    if (rst_sync) begin
      shreg <= '0;
    end else begin
      shreg <= {i_link_data, shreg[MSG_BITS-1:1]};
    end
  end
endmodule

// File: design/dpk_top.sv
/*
  Decoder provisioning and key generation: programming entry detection,
  download check and storage, erase of the transmitter slots with the test
  transmitter, learn bookkeeping and key derivation.
  Assumes a cipher engine on the core clock answers each request with a
  one-cycle done pulse, and that learn and receive events come from logic
  on the core clock.
*/
`timescale 1ns/1ns
module dpk_top #(
  parameter logic [dpk_pkg::TIMER_W-1:0] P_SETUP_MIN_CYC = dpk_pkg::SETUP_MIN_CYC,
  parameter logic [dpk_pkg::TIMER_W-1:0] P_SETUP_MAX_CYC = dpk_pkg::SETUP_MAX_CYC,
  parameter logic [dpk_pkg::TIMER_W-1:0] P_HOLD_MIN_CYC = dpk_pkg::HOLD_MIN_CYC,
  parameter logic [dpk_pkg::TIMER_W-1:0] P_HOLD_MAX_CYC = dpk_pkg::HOLD_MAX_CYC,
  parameter logic [dpk_pkg::TIMER_W-1:0] P_PHASE_MAX_CYC = dpk_pkg::PHASE_MAX_CYC,
  parameter logic [dpk_pkg::TIMER_W-1:0] P_STATUS_CYC = dpk_pkg::STATUS_CYC,
  parameter logic [dpk_pkg::TIMER_W-1:0] P_BLINK_CYC = dpk_pkg::BLINK_CYC
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Programming link
  input wire logic i_prog_clk,
  input wire logic i_prog_data,
  output logic o_prog_data,
  output logic o_prog_data_oe,
  output logic o_prog_mode,
  // Stored setup
  output logic [dpk_pkg::BYTE_W-1:0] o_setup_options_byte,
  output logic o_code_loaded,
  // Learning
  input wire logic i_learn_request_n,
  input wire logic i_learn_first,
  input wire logic i_learn_done,
  input wire logic [dpk_pkg::HALF_W-1:0] i_learn_serial,
  output logic o_learn_fail,
  output logic o_learn_indicator,
  output logic o_test_tx_present,
  output logic [dpk_pkg::SLOT_W-1:0] o_learned_count,
  // Reception
  input wire logic i_rx_valid,
  input wire logic [dpk_pkg::HALF_W-1:0] i_rx_serial,
  output logic o_rx_test_accept,
  // Key generation
  input wire logic i_keygen_start,
  input wire dpk_pkg::dpk_txlen_t i_tx_len,
  input wire dpk_pkg::dpk_seedkind_t i_seed_kind,
  input wire logic [dpk_pkg::CODE_BITS-1:0] i_seed_value,
  output logic [dpk_pkg::CODE_BITS-1:0] o_key,
  output logic o_key_valid,
  // Cipher engine
  output logic o_cipher_req,
  output logic [dpk_pkg::HALF_W-1:0] o_cipher_word,
  output logic [dpk_pkg::CODE_BITS-1:0] o_cipher_key,
  input wire logic i_cipher_done,
  input wire logic [dpk_pkg::HALF_W-1:0] i_cipher_word,
  // Power
  output logic o_sleep_allow
);
  import dpk_pkg::*;

  function automatic logic [CNT_W-1:0] gray2bin(input logic [CNT_W-1:0] g);
    logic [CNT_W-1:0] b;
    b = '0;
    for (int i = CNT_W - 1; i >= 0; i--) begin
      b[i] = (i == CNT_W - 1) ? g[i] : (b[i+1] ^ g[i]);
    end
    return b;
  endfunction

  function automatic logic [BYTE_W-1:0] byte_sum(input logic [MSG_BITS-1:0] m);
    logic [BYTE_W-1:0] s;
    s = '0;
    for (int i = 0; i < MSG_BYTES; i++) begin
      s = s + m[i*BYTE_W +: BYTE_W];
    end
    return s;
  endfunction

  dpk_link_if lnk ();

  dpk_prog_link u_link (
    .i_link_clk(i_prog_clk),
    .i_link_data(i_prog_data),
    .i_sys_rst(i_sys_rst),
    .lnk(lnk.link)
  );

  dpk_state_t state;
  dpk_state_t next_state;
  dpk_kg_state_t kg_state;
  dpk_kg_state_t next_kg_state;

  logic clk_meta;
  logic clk_sync;
  logic clk_prev;
  logic lrq_meta;
  logic lrq_sync;
  logic lrq_prev;
  logic [CNT_W-1:0] g_meta;
  logic [CNT_W-1:0] g_sync;

  logic [TIMER_W-1:0] up_cnt;
  logic [TIMER_W-1:0] ph_cnt;
  logic [TIMER_W-1:0] ack_cnt;
  logic [TIMER_W-1:0] ind_cnt;
  logic [TIMER_W-1:0] blink_cnt;
  logic [CNT_W-1:0] bit_base;
  logic [MSG_BITS-1:0] msg;
  logic [CODE_BITS-1:0] mfr_code;
  logic [BYTE_W-1:0] cfg;
  logic [SLOT_W-1:0] erase_idx;
  logic [SLOT_W-1:0] ovw_ptr;
  logic [SLOTS-1:0] slot_valid;
  logic [SLOTS-1:0][HALF_W-1:0] slot_serial;
  logic test_present;
  logic ind_active;
  logic [HALF_W-1:0] seed_lo;

  // Link edge detection and decoded conditions
  logic clk_rise;
  logic clk_fall;
  logic lrq_fall;
  logic [CNT_W-1:0] link_cnt;
  logic [CNT_W-1:0] bits_in;
  logic msg_done;
  logic sum_ok;
  logic erase_last;
  logic ack_last;
  logic hold_ok;
  logic learn_store;
  logic [SLOT_W-1:0] free_idx;
  logic free_found;
  logic [SLOT_W-1:0] store_idx;
  logic [HALF_W-1:0] norm_up;
  logic [HALF_W-1:0] norm_lo;
  logic [HALF_W-1:0] sec_up;
  logic [HALF_W-1:0] src_up;
  logic [HALF_W-1:0] src_lo;
  logic algo_xor;
  logic prog_busy;

  assign clk_rise = clk_sync & ~clk_prev;
  assign clk_fall = ~clk_sync & clk_prev;
  assign lrq_fall = ~lrq_sync & lrq_prev;
  assign link_cnt = gray2bin(g_sync);
  assign bits_in = link_cnt - bit_base;
  assign msg_done = bits_in == CNT_W'(MSG_BITS);
  assign sum_ok = byte_sum(msg) == '0;
  assign erase_last = erase_idx == SLOT_W'(SLOTS - 1);
  assign ack_last = ack_cnt == ACK_PULSE_CYC - 1'b1;
  assign hold_ok = (ph_cnt > P_HOLD_MIN_CYC) && (ph_cnt <= P_HOLD_MAX_CYC);
  assign prog_busy = (state != ST_RUN) && (state != ST_WAIT_LOW);
  assign algo_xor = cfg[CFG_KEY_ALGO_BIT];

  // Slot search for learning; full memory overwrites in rotation
  always_comb begin
    free_idx = '0;
    free_found = 1'b0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (!slot_valid[i]) begin
        free_idx = SLOT_W'(i);
        free_found = 1'b1;
      end
    end
  end

  assign store_idx = free_found ? free_idx : ovw_ptr;
  assign learn_store = i_learn_done && (i_learn_serial != '0) && (state == ST_RUN);

  // Seed composition
  assign norm_up = (i_tx_len == TX_LEN_56) ? {SEED_PFX24_UP, i_learn_serial[SER24_W-1:0]}
                                           : {SEED_PFX28_UP, i_learn_serial[SER28_W-1:0]};
  assign norm_lo = (i_tx_len == TX_LEN_56) ? {SEED_PFX24_LO, i_learn_serial[SER24_W-1:0]}
                                           : {SEED_PFX28_LO, i_learn_serial[SER28_W-1:0]};
  // Seed kinds other than 32-bit share one path, so 64-bit seeds use bits 47:32
  assign sec_up = (i_seed_kind == SEED_32) ? {FUNC_ZERO, i_learn_serial[SER28_W-1:0]}
    : ({i_seed_value[HALF_W +: SER_HI_W], i_learn_serial[HALF_W-1 -: SER_HI_W]}
       & SEED_TOP_MASK);
  assign src_up = cfg[CFG_SEED_LEARN_BIT] ? sec_up : norm_up;
  assign src_lo = cfg[CFG_SEED_LEARN_BIT] ? i_seed_value[HALF_W-1:0] : norm_lo;

  always_ff @(posedge i_core_clk) begin
    clk_meta <= i_prog_clk;
    clk_sync <= clk_meta;
    clk_prev <= clk_sync;
    lrq_meta <= i_learn_request_n;
    lrq_sync <= lrq_meta;
    lrq_prev <= lrq_sync;
    g_meta <= lnk.cnt_gray;
    g_sync <= g_meta;
  end

  // Entry and download sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_WAIT_LOW: begin
        if (up_cnt > P_SETUP_MAX_CYC) begin
          next_state = ST_RUN;
        end else if (clk_rise && (ph_cnt >= P_SETUP_MIN_CYC)) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (clk_fall) begin
          next_state = hold_ok ? ST_PROG : ST_RUN;
        end else if (ph_cnt > P_HOLD_MAX_CYC) begin
          next_state = ST_RUN;
        end
      end
      ST_PROG: begin
        if (msg_done) begin
          next_state = ST_CHECK;
        end else if (ph_cnt > P_PHASE_MAX_CYC) begin
          next_state = ST_RUN;
        end
      end
      ST_CHECK: begin
        next_state = sum_ok ? ST_ACK : ST_RUN;
      end
      ST_ACK: begin
        if (ack_last) begin
          next_state = ST_ERASE;
        end
      end
      ST_ERASE: begin
        if (erase_last) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state <= ST_WAIT_LOW;
      up_cnt <= '0;
      ph_cnt <= '0;
    end else begin
      state <= next_state;
      up_cnt <= (up_cnt == '1) ? up_cnt : up_cnt + 1'b1;
      ph_cnt <= (clk_rise || clk_fall) ? '0 : ((ph_cnt == '1) ? ph_cnt : ph_cnt + 1'b1);
    end
  end

  // The edge count is free running, so the accepting fall takes a baseline
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      bit_base <= '0;
      msg <= '0;
      ack_cnt <= '0;
      erase_idx <= '0;
    end else begin
      if (state == ST_HOLD && clk_fall) begin
        bit_base <= link_cnt;
      end
      if (state == ST_PROG && msg_done) begin
        msg <= lnk.word;
      end
      ack_cnt <= (state == ST_ACK) ? ack_cnt + 1'b1 : '0;
      erase_idx <= (state == ST_ERASE) ? erase_idx + 1'b1 : '0;
    end
  end

  // Flops stand in for the nonvolatile store, so a reset loses the code
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      mfr_code <= '0;
      cfg <= CFG_RESET;
      o_code_loaded <= 1'b0;
    end else if (state == ST_CHECK && sum_ok) begin
      mfr_code <= msg[CODE_BITS-1:0];
      cfg <= msg[CFG_BYTE_IDX*BYTE_W +: BYTE_W];
      o_code_loaded <= 1'b1;
    end
  end

  // Acknowledge drives the data line high; it starts right after the check
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_prog_data <= 1'b0;
      o_prog_data_oe <= 1'b0;
      o_prog_mode <= 1'b0;
    end else begin
      o_prog_data <= next_state == ST_ACK;
      o_prog_data_oe <= next_state == ST_ACK;
      o_prog_mode <= (next_state != ST_RUN) && (next_state != ST_WAIT_LOW);
    end
  end

  // Transmitter slots
  for (genvar i = 0; i < SLOTS; i++) begin : g_slot
    logic wipe;
    logic fill;
    assign wipe = (state == ST_ERASE) && (erase_idx == SLOT_W'(i));
    assign fill = learn_store && (store_idx == SLOT_W'(i));
    always_ff @(posedge i_core_clk) begin
      if (i_sys_rst || wipe) begin
        slot_valid[i] <= 1'b0;
        slot_serial[i] <= '0;
      end else if (fill) begin
        slot_valid[i] <= 1'b1;
        slot_serial[i] <= i_learn_serial;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      test_present <= 1'b0;
      ovw_ptr <= '0;
    end else begin
      if (state == ST_ERASE && erase_last) begin
        test_present <= 1'b1;
      end else if (learn_store) begin
        test_present <= 1'b0;
      end
      if (learn_store && !free_found) begin
        ovw_ptr <= ovw_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_rx_test_accept <= 1'b0;
      o_learn_fail <= 1'b0;
      o_test_tx_present <= 1'b0;
      o_learned_count <= '0;
    end else begin
      o_rx_test_accept <= i_rx_valid && (i_rx_serial == '0) && test_present;
      o_learn_fail <= i_learn_first && (i_learn_serial == '0);
      o_test_tx_present <= test_present;
      o_learned_count <= free_found ? free_idx - 1'b1 : SLOT_W'(SLOTS - 1);
    end
  end

  // Learn status indication; a new learn restarts it even if a press ends it
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      ind_active <= 1'b0;
      ind_cnt <= '0;
      blink_cnt <= '0;
      o_learn_indicator <= 1'b0;
    end else if (learn_store) begin
      ind_active <= 1'b1;
      ind_cnt <= '0;
      blink_cnt <= '0;
      o_learn_indicator <= 1'b1;
    end else if (ind_active && (lrq_fall || ind_cnt == P_STATUS_CYC - 1'b1)) begin
      ind_active <= 1'b0;
      o_learn_indicator <= 1'b0;
    end else if (ind_active) begin
      ind_cnt <= ind_cnt + 1'b1;
      blink_cnt <= (blink_cnt == P_BLINK_CYC - 1'b1) ? '0 : blink_cnt + 1'b1;
      if (blink_cnt == P_BLINK_CYC - 1'b1) begin
        o_learn_indicator <= ~o_learn_indicator;
      end
    end
  end

  // Key generation
  always_comb begin
    next_kg_state = kg_state;
    case (kg_state)
      KG_IDLE: begin
        if (i_keygen_start && !algo_xor) begin
          next_kg_state = KG_UP;
        end
      end
      KG_UP: begin
        if (i_cipher_done) begin
          next_kg_state = KG_LO;
        end
      end
      KG_LO: begin
        if (i_cipher_done) begin
          next_kg_state = KG_IDLE;
        end
      end
      default: begin
        next_kg_state = KG_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      kg_state <= KG_IDLE;
      seed_lo <= '0;
      o_key <= '0;
      o_key_valid <= 1'b0;
      o_cipher_req <= 1'b0;
      o_cipher_word <= '0;
    end else begin
      kg_state <= next_kg_state;
      o_key_valid <= 1'b0;
      o_cipher_req <= 1'b0;
      if (kg_state == KG_IDLE && i_keygen_start) begin
        seed_lo <= src_lo;
        if (algo_xor) begin
          o_key <= {src_up ^ mfr_code[CODE_BITS-1:HALF_W], src_lo ^ mfr_code[HALF_W-1:0]};
          o_key_valid <= 1'b1;
        end else begin
          o_cipher_word <= src_up;
          o_cipher_req <= 1'b1;
        end
      end else if (kg_state == KG_UP && i_cipher_done) begin
        o_key[CODE_BITS-1:HALF_W] <= i_cipher_word;
        o_cipher_word <= seed_lo;
        o_cipher_req <= 1'b1;
      end else if (kg_state == KG_LO && i_cipher_done) begin
        o_key[HALF_W-1:0] <= i_cipher_word;
        o_key_valid <= 1'b1;
      end
    end
  end

  assign o_cipher_key = mfr_code;
  assign o_setup_options_byte = cfg;

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_sleep_allow <= 1'b0;
    end else begin
      o_sleep_allow <= cfg[CFG_SLEEP_BIT] && !prog_busy && (state == ST_RUN)
                       && !ind_active && (kg_state == KG_IDLE);
    end
  end
endmodule

// File: test/dpk_top_asserts.sv
/* Port-level assertions for the provisioning block.
   Assumes it is bound to dpk_top and clocked by its core clock. */
`timescale 1ns/1ns
module dpk_top_asserts (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  // Watched ports
  input wire logic o_prog_data,
  input wire logic o_prog_data_oe,
  input wire logic o_prog_mode,
  input wire logic o_code_loaded,
  input wire logic o_test_tx_present,
  input wire logic i_learn_first,
  input wire logic [31:0] i_learn_serial,
  input wire logic o_learn_fail,
  input wire logic i_rx_valid,
  input wire logic [31:0] i_rx_serial,
  input wire logic o_rx_test_accept,
  input wire logic [7:0] o_setup_options_byte,
  input wire logic o_sleep_allow
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_ack_up;
    $rose(o_prog_data);
  endsequence
  sequence s_ack_held;
    o_prog_data [*8];
  endsequence
  a_ack_drives_pin: assert property (
    o_prog_data |-> o_prog_data_oe) else $error("ack without enable");
  a_ack_min_width: assert property (
    s_ack_up |-> s_ack_held) else $error("ack too short");
  a_ack_after_store: assert property (
    s_ack_up |-> o_code_loaded) else $error("ack before store");
  a_erase_follows: assert property (
    $fell(o_prog_data) |-> ##[1:8] !o_prog_mode) else $error("no erase after ack");
  a_test_installed: assert property (
    $fell(o_prog_mode) && o_code_loaded |-> ##[0:2] o_test_tx_present)
    else $error("test entry missing");
  a_zero_learn_fail: assert property (
    $rose(o_learn_fail) |-> $past(i_learn_first) && $past(i_learn_serial) == 32'h0)
    else $error("learn fail without zero serial");
  a_rx_test_only: assert property (
    o_rx_test_accept |-> $past(i_rx_valid) && $past(i_rx_serial) == 32'h0)
    else $error("test accept on wrong serial");
  a_sleep_gate: assert property (
    o_sleep_allow |-> o_setup_options_byte[3]) else $error("sleep not enabled");
endmodule

bind dpk_top dpk_top_asserts u_asserts (.i_core_clk, .i_sys_rst, .o_prog_data,
  .o_prog_data_oe, .o_prog_mode, .o_code_loaded, .o_test_tx_present, .i_learn_first,
  .i_learn_serial, .o_learn_fail, .i_rx_valid, .i_rx_serial, .o_rx_test_accept,
  .o_setup_options_byte, .o_sleep_allow);

// File: test/dpk_prog_model.sv
/* Production programmer model: drives the programming clock and data.
   Assumes the bench resolves the shared data wire into i_wire. */
`timescale 1ns/1ns
module dpk_prog_model (
  // Pins
  output logic o_clk,
  output logic o_data,
  input wire logic i_wire
);
  initial begin
    o_clk = 1'b0;
    o_data = 1'b0;
  end
  // Clock stands low between uses
  task automatic tick(input int n);
    repeat (n) begin
      #15 o_clk = 1'b1;
      #15 o_clk = 1'b0;
    end
  endtask
  task automatic enter();
    #2000 o_clk = 1'b1;
    #20000 o_clk = 1'b0;
    #1000;
  endtask
  // Released line toggles so a stale level never fakes the ack
  task automatic send(input logic [79:0] m, output logic ack);
    int run;
    for (int i = 0; i < 80; i++) begin
      o_data = m[i];
      tick(1);
    end
    ack = 1'b0;
    run = 0;
    repeat (300) begin
      o_data = ~o_data;
      #10;
      run = (i_wire === 1'b1) ? run + 1 : 0;
      if (run > 2) ack = 1'b1;
    end
  endtask
endmodule

// File: test/decoder_provisioning_keygen_tb.sv
/* Self-checking bench: XOR setup run, seed and decrypt run, bad checksum run.
   Assumes shortened entry minimums and status counts set at the instance;
   upper entry and phase limits keep their full length. */
`timescale 1ns/1ns
module decoder_provisioning_keygen_tb;
  import dpk_pkg::*;
  logic clk, rst, m_clk, m_data, d_out, d_oe, mode, loaded, fail, ind, ttx, acc, kv, creq, slp;
  logic lreq_n = 1'b1, lfirst = 1'b0, ldone = 1'b0, rxv = 1'b0, kgs = 1'b0, cdone = 1'b0;
  logic [31:0] lser = 32'h0, rxs = 32'h0, cword, cw_q = 32'h0;
  logic [63:0] seed = 64'h0, key, ckey, code;
  logic [7:0] setup;
  logic [1:0] lcnt;
  dpk_txlen_t len = TX_LEN_56;
  dpk_seedkind_t kind = SEED_32;
  int err_count, samples_checked, n_acc, n_fail, cdly;
  wire prog_lvl = d_oe ? d_out : m_data;
  dpk_prog_model pm (.o_clk(m_clk), .o_data(m_data), .i_wire(prog_lvl));
  dpk_top #(.P_SETUP_MIN_CYC(32'h64), .P_HOLD_MIN_CYC(32'h320), .P_STATUS_CYC(32'h190),
    .P_BLINK_CYC(32'h19)) dut (.i_core_clk(clk), .i_sys_rst(rst), .i_prog_clk(m_clk),
    .i_prog_data(prog_lvl), .o_prog_data(d_out), .o_prog_data_oe(d_oe), .o_prog_mode(mode),
    .o_setup_options_byte(setup), .o_code_loaded(loaded), .i_learn_request_n(lreq_n),
    .i_learn_first(lfirst), .i_learn_done(ldone), .i_learn_serial(lser), .o_learn_fail(fail),
    .o_learn_indicator(ind), .o_test_tx_present(ttx), .o_learned_count(lcnt), .i_rx_valid(rxv),
    .i_rx_serial(rxs), .o_rx_test_accept(acc), .i_keygen_start(kgs), .i_tx_len(len),
    .i_seed_kind(kind), .i_seed_value(seed), .o_key(key), .o_key_valid(kv),
    .o_cipher_req(creq), .o_cipher_word(cword), .o_cipher_key(ckey), .i_cipher_done(cdone),
    .i_cipher_word(~cw_q), .o_sleep_allow(slp));
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (acc === 1'b1) n_acc++;
    if (fail === 1'b1) n_fail++;
  end
  // Stand-in cipher: inverts the word after a short delay
  always @(negedge clk) begin
    cdone <= (creq !== 1'b1) && (cdly == 1);
    if (creq === 1'b1) begin
      cw_q <= cword;
      cdly <= 3;
      chk(ckey, code);
    end else if (cdly > 0) begin
      cdly <= cdly - 1;
    end
  end
  task automatic tally_and_finish();
    if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 3000) begin
      err_count++;
      $display("ERROR %0t wait ran out", $time);
      tally_and_finish();
    end
  endtask
  task automatic boot(input logic [7:0] cfg, input logic bad, input logic [63:0] c);
    logic [79:0] m;
    logic [7:0] s;
    logic ack;
    int n;
    @(negedge clk) rst = 1'b1;
    code = c;
    m = {8'h00, cfg, c};
    s = 8'h00;
    for (int i = 0; i < 9; i++) s = s + m[8*i +: 8];
    m[79:72] = 8'h00 - s + {7'h00, bad};
    pm.tick(4);
    @(negedge clk) rst = 1'b0;
    // Link-side reset clears only on link edges after release
    pm.tick(1);
    pm.enter();
    pm.send(m, ack);
    chk(64'(ack), 64'(!bad));
    chk(64'(setup), bad ? 64'h0 : 64'(cfg));
    chk(64'(loaded), 64'(!bad));
    for (n = 0; n < 3000 && mode !== 1'b0; n++) @(negedge clk);
    tmo(n);
    repeat (3) @(negedge clk);
    chk(64'(ttx), 64'(!bad));
    chk(64'(slp), 64'(cfg[3] & !bad));
  endtask
  task automatic kg(input dpk_txlen_t l, input dpk_seedkind_t k, input logic [31:0] sr,
      input logic [63:0] sd, input logic [63:0] exp);
    int n;
    @(negedge clk);
    len = l;
    kind = k;
    lser = sr;
    seed = sd;
    kgs = 1'b1;
    @(negedge clk) kgs = 1'b0;
    for (n = 0; n < 3000 && kv !== 1'b1; n++) @(negedge clk);
    tmo(n);
    chk(key, exp);
  endtask
  task automatic rx(input logic [31:0] s, input int exp);
    n_acc = 0;
    @(negedge clk) rxv = 1'b1;
    rxs = s;
    @(negedge clk) rxv = 1'b0;
    repeat (4) @(negedge clk);
    chk(64'(n_acc), 64'(exp));
  endtask
  // Zero serial learn fails, real learn drops test entry, short request ends status
  task automatic learn_flow();
    n_fail = 0;
    @(negedge clk) lfirst = 1'b1;
    lser = 32'h0;
    @(negedge clk) lfirst = 1'b0;
    ldone = 1'b1;
    lser = 32'h0000_1234;
    @(negedge clk) ldone = 1'b0;
    repeat (3) @(negedge clk);
    chk(64'(n_fail), 64'h1);
    chk(64'(ttx), 64'h0);
    chk(64'(ind), 64'h1);
    lreq_n = 1'b0;
    repeat (2) @(negedge clk);
    lreq_n = 1'b1;
    repeat (8) @(negedge clk);
    chk(64'(ind), 64'h0);
    @(negedge clk) ldone = 1'b1;
    lser = 32'h0000_5678;
    @(negedge clk) ldone = 1'b0;
    repeat (2) @(negedge clk);
    chk(64'(lcnt), 64'h1);
  endtask
  initial begin
    #500000;
    err_count++;
    $display("ERROR %0t run too long", $time);
    tally_and_finish();
  end
  initial begin
    boot(8'h01, 1'b0, 64'h0123_4567_89AB_CDEF);
    rx(32'h0, 1);
    rx(32'h5, 0);
    kg(TX_LEN_56, SEED_32, 32'h00AB_CDEF, 64'h0, {32'h65AB_CDEF ^ code[63:32],
      32'h2BAB_CDEF ^ code[31:0]});
    kg(TX_LEN_66, SEED_32, 32'hF987_6543, 64'h0, {32'h6987_6543 ^ code[63:32],
      32'h2987_6543 ^ code[31:0]});
    kg(TX_LEN_67, SEED_48, 32'hF987_6543, 64'h0, {32'h6987_6543 ^ code[63:32],
      32'h2987_6543 ^ code[31:0]});
    learn_flow();
    rx(32'h0, 0);
    boot(8'h0C, 1'b0, 64'hFEDC_BA98_7654_3210);
    kg(TX_LEN_66, SEED_32, 32'hF123_4567, 64'h0000_0000_89AB_CDEF,
      {~32'h0123_4567, ~32'h89AB_CDEF});
    kg(TX_LEN_56, SEED_48, 32'hF123_4567, 64'h0000_5A5A_89AB_CDEF,
      {~32'h0A5A_F123, ~32'h89AB_CDEF});
    kg(TX_LEN_56, SEED_64, 32'hF123_4567, 64'hC3C3_5A5A_89AB_CDEF,
      {~32'h0A5A_F123, ~32'h89AB_CDEF});
    boot(8'h01, 1'b1, 64'h0123_4567_89AB_CDEF);
    tally_and_finish();
  end
endmodule
